// ---- design/digit_store_read_scanner.sv ----
// Fourteen-slot digit store with its read scanner and two-phase pulse clock.
// Assumes the tone receiver and the translation logic sit on the same clock.
// Assumes the translation logic returns restart only after the interdigital time.

module digit_store_read_scanner
	import digit_store_pkg::*;
#(
	parameter int SLOTS = SLOT_COUNT,
	parameter int BITS = BIT_COUNT,
	parameter int DEPTH = BUF_DEPTH,
	parameter int PHASE_GAP = PHASE_GAP_CYC
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic write_word,
	input wire logic [BITS-1:0] bit_sel,
	input wire logic wr_advance,
	input wire logic restart,
	input wire logic out_ready,
	output logic first_clock_phase,
	output logic second_clock_phase,
	output logic [SLOTS-1:0] rd_slot,
	output logic [SLOTS-1:0] wr_slot,
	output logic scanning,
	output logic [BITS-1:0] bit_strobe,
	output logic digit_present,
	output logic out_valid,
	output logic [BITS-1:0] out_bits,
	output logic [3:0] out_digit,
	output logic out_code_err
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam int DW = $clog2(PHASE_GAP + 1);
	localparam int A_GAP = PHASE_GAP;

	typedef struct packed {
		logic err;
		logic [3:0] digit;
		logic [BITS-1:0] bits;
	} entry_t;

	typedef struct packed {
		logic [DW-1:0] div;
		logic phase_sel;
		logic tr_p;
		logic tw_p;
		logic [SLOTS-1:0][BITS-1:0] store;
		logic [SLOTS-1:0] wr_ptr;
		logic [SLOTS-1:0] rd_ptr;
		scan_state_t state;
		logic [BITS-1:0] strobe;
		logic present;
		logic [DEPTH-1:0] [$bits(entry_t)-1:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [CW-1:0] cnt;
	} state_t;

	state_t s_r;
	state_t s_nxt;

	////////////////////////////////////////////////////////////////////////
	// Helpers.

	function automatic logic [SLOTS-1:0] step_ptr(input logic [SLOTS-1:0] p);
		if (p == '0) begin
			step_ptr = {{(SLOTS-1){1'b0}}, 1'b1};
		end else begin
			step_ptr = {p[SLOTS-2:0], p[SLOTS-1]};
		end
	endfunction

	function automatic logic [BITS-1:0] slot_word(input logic [SLOTS-1:0][BITS-1:0] st,
			input logic [SLOTS-1:0] p);
		slot_word = '0;
		for (int i = 0; i < SLOTS; i++) begin
			if (p[i]) begin
				slot_word = slot_word | st[i];
			end
		end
	endfunction

	function automatic logic [3:0] decode_digit(input logic [BITS-1:0] b);
		decode_digit = DIGIT_ZERO;
		if (b[BIT_W1]) begin
			decode_digit = decode_digit + WEIGHT_1;
		end
		if (b[BIT_W2]) begin
			decode_digit = decode_digit + WEIGHT_2;
		end
		if (b[BIT_W4]) begin
			decode_digit = decode_digit + WEIGHT_4;
		end
		if (b[BIT_W6]) begin
			decode_digit = decode_digit + WEIGHT_6;
		end
		if (b[BIT_W8]) begin
			decode_digit = decode_digit + WEIGHT_8;
		end
	endfunction

	// A single set cell is any digit; a pair must be weight 1 with 2, 4, 6 or 8.
	function automatic logic code_legal(input logic [BITS-1:0] b);
		code_legal = 1'b0;
		if ($countones(b) == 1) begin
			code_legal = 1'b1;
		end else if ($countones(b) == 2) begin
			code_legal = b[BIT_W1] && !b[BIT_ZERO];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	logic advance;
	logic push;
	logic pop;
	logic [SLOTS-1:0] next_slot;
	logic [BITS-1:0] read_word;
	entry_t head;

	always_comb begin
		s_nxt = s_r;
		head = entry_t'(s_r.mem[s_r.rp]);
		s_nxt.tr_p = 1'b0;
		s_nxt.tw_p = 1'b0;
		if (s_r.div == DW'(PHASE_GAP - 1)) begin
			s_nxt.div = '0;
			s_nxt.phase_sel = !s_r.phase_sel;
			s_nxt.tr_p = !s_r.phase_sel;
			s_nxt.tw_p = s_r.phase_sel;
		end else begin
			s_nxt.div = s_r.div + DW'(1);
		end

		if (s_r.tw_p && write_word) begin
			for (int i = 0; i < SLOTS; i++) begin
				if (s_r.wr_ptr[i]) begin
					s_nxt.store[i] = s_r.store[i] | bit_sel;
				end
			end
		end
		if (wr_advance) begin
			s_nxt.wr_ptr = step_ptr(s_r.wr_ptr);
		end

		// A full buffer stalls the scanner so that no read word is dropped.
		// Advance on each first phase while scanning and the buffer has room
		advance = s_r.tr_p && (s_r.state == ST_SCAN) && (s_r.cnt < CW'(DEPTH));
		next_slot = step_ptr(s_r.rd_ptr);
		read_word = slot_word(s_r.store, next_slot);
		push = advance && (read_word != '0);
		s_nxt.strobe = '0;
		s_nxt.present = 1'b0;
		if (advance) begin
			s_nxt.rd_ptr = next_slot;
			for (int i = 0; i < SLOTS; i++) begin
				if (next_slot[i]) begin
					s_nxt.store[i] = '0;
				end
			end
			s_nxt.strobe = read_word;
			s_nxt.present = read_word != '0;
		end

		// Halt in the same cycle as the read
		if (push) begin
			s_nxt.state = ST_HALT;
		end else if (s_r.state == ST_HALT && s_r.tw_p && restart) begin
			s_nxt.state = ST_SCAN;
		end

		pop = (s_r.cnt != '0) && out_ready;
		if (push) begin
			s_nxt.mem[s_r.wp] = {!code_legal(read_word), decode_digit(read_word), read_word};
			s_nxt.wp = (s_r.wp == PW'(DEPTH - 1)) ? '0 : s_r.wp + PW'(1);
		end
		if (pop) begin
			s_nxt.rp = (s_r.rp == PW'(DEPTH - 1)) ? '0 : s_r.rp + PW'(1);
		end
		if (push && !pop) begin
			s_nxt.cnt = s_r.cnt + CW'(1);
		end else if (pop && !push) begin
			s_nxt.cnt = s_r.cnt - CW'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register.

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_r <= '0;
			s_r.store <= '0;
			s_r.wr_ptr <= WR_PTR_RST;
			s_r.rd_ptr <= RD_PTR_RST;
			s_r.state <= ST_SCAN;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign first_clock_phase = s_r.tr_p;
	assign second_clock_phase = s_r.tw_p;
	assign rd_slot = s_r.rd_ptr;
	assign wr_slot = s_r.wr_ptr;
	assign scanning = s_r.state == ST_SCAN;
	assign bit_strobe = s_r.strobe;
	assign digit_present = s_r.present;
	assign out_valid = s_r.cnt != '0;
	assign out_bits = head.bits;
	assign out_digit = head.digit;
	assign out_code_err = head.err;

	////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_reset_empty: assert property (disable iff (1'b0) rst |=> (s_r.store == '0))
		else $error("store not empty after seizure reset");

	a_cell_coincide: assert property (((s_r.store & ~$past(s_r.store)) != '0) |->
			$past(second_clock_phase && write_word && (bit_sel != '0)))
		else $error("cell set without coincident selects");

	a_code_legal: assert property (out_valid && !out_code_err |->
			($countones(out_bits) == 1 || $countones(out_bits) == 2))
		else $error("legal flag on a bad code");

	a_digit_decode: assert property (out_valid |-> out_digit == decode_digit(out_bits))
		else $error("digit value does not match weights");

	a_wr_wrap: assert property (wr_advance && wr_slot[SLOTS-1] |=> wr_slot[0])
		else $error("write pointer failed to wrap");

	a_phase_alt: assert property (first_clock_phase |-> ##A_GAP second_clock_phase)
		else $error("second phase did not follow first phase");

	a_first_read: assert property (first_clock_phase && (rd_slot == '0) |=>
			rd_slot[0])
		else $error("first advance did not read slot one");

	a_ptr_onehot: assert property (rd_slot != '0 |-> $onehot(rd_slot))
		else $error("read pointer not one-hot");

	a_read_clear: assert property (digit_present |-> slot_word(s_r.store, rd_slot) == '0)
		else $error("slot not cleared by read");

	sequence seq_found;
		digit_present;
	endsequence

	sequence seq_held;
		(!scanning && $stable(rd_slot))[*8];
	endsequence

	a_halt_found: assert property (seq_found |=> seq_held)
		else $error("scanner advanced after finding a digit");

	a_restart_next: assert property (!scanning && second_clock_phase && restart |->
			##A_GAP (first_clock_phase && scanning))
		else $error("restart not followed by first-phase advance");

	a_scan_free: assert property (scanning && first_clock_phase && s_r.cnt < CW'(DEPTH) |=>
			rd_slot != $past(rd_slot))
		else $error("scanner skipped a first-phase advance");

	a_strobe_tr: assert property (digit_present |-> $past(first_clock_phase) && bit_strobe != '0)
		else $error("bit strobe not timed with first phase");

	a_stop_early: assert property (digit_present |-> !scanning)
		else $error("halt not resolved before next advance");

endmodule

// ---- design/digit_store_pkg.sv ----
// Constants and types shared by the digit store and its read-side scanner.
// Assumes one 50 MHz system clock and a synchronous, active-high seizure reset.
package digit_store_pkg;

	localparam int SLOT_COUNT = 14;
	localparam int BIT_COUNT = 6;
	localparam int BUF_DEPTH = 2;

	// Field positions of the six bit cells of a slot.
	localparam int BIT_W1 = 0;
	localparam int BIT_W2 = 1;
	localparam int BIT_W4 = 2;
	localparam int BIT_W6 = 3;
	localparam int BIT_W8 = 4;
	localparam int BIT_ZERO = 5;

	// Digit values added for each weighted bit.
	localparam logic [3:0] WEIGHT_1 = 4'h1;
	localparam logic [3:0] WEIGHT_2 = 4'h2;
	localparam logic [3:0] WEIGHT_4 = 4'h4;
	localparam logic [3:0] WEIGHT_6 = 4'h6;
	localparam logic [3:0] WEIGHT_8 = 4'h8;
	localparam logic [3:0] DIGIT_ZERO = 4'h0;

	// Timing of the two-phase pulse clock.
	localparam int CLK_PERIOD_NS = 20;
	localparam int PHASE_GAP_NS = 1000;
	localparam int PHASE_GAP_CYC = (PHASE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Reset values.
	localparam logic [SLOT_COUNT-1:0] WR_PTR_RST = 14'h0001;
	localparam logic [SLOT_COUNT-1:0] RD_PTR_RST = 14'h0000;

	typedef enum logic [0:0] {
		ST_SCAN,
		ST_HALT
	} scan_state_t;

endpackage

// ---- tb/translation_model.sv ----
// Behavioural translation logic at the far side of the scanner's output.
// Assumes one clock shared with the scanner and a synchronous active-high reset.
module translation_model #(
	parameter int GAP = 20
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic digit_present,
	input wire logic scanning,
	input wire logic stall,
	output logic restart,
	output logic out_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt_r;
	logic busy_r;
	////////////////////////////////////////////////////////////////
	// Stop on digit.
	// Restart until resumed.
	// Restart stays a level until scanning resumes, so it always covers a second phase.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			busy_r <= 1'b0;
			cnt_r <= 8'h00;
			restart <= 1'b0;
		end else if (digit_present) begin
			busy_r <= 1'b1;
			cnt_r <= 8'(GAP);
			restart <= 1'b0;
		end else if (busy_r && cnt_r != 8'h00) begin
			cnt_r <= cnt_r - 8'h01;
		end else if (busy_r) begin
			restart <= !scanning;
			busy_r <= !scanning;
		end
	end
	// The bench stalls the receiver to fill the two-entry buffer.
	assign out_ready = !stall;
endmodule

// ---- tb/test_digit_store_read_scanner.sv ----
// Self-checking bench for the digit store and its read scanner.
// Assumes the translation model answers restart and out_ready.
module test_digit_store_read_scanner
	import digit_store_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int PG = 4;
	localparam logic [5:0] CODES [11] = '{6'h20, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h08, 6'h09, 6'h10, 6'h11,
		6'h07};
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic write_word = 1'b0;
	logic wr_advance = 1'b0;
	logic stall = 1'b0;
	logic [5:0] bit_sel = 6'h00;
	logic restart, out_ready, fp, sp, scanning, digit_present, out_valid, code_err;
	logic [13:0] rd_slot, wr_slot, s;
	logic [5:0] bit_strobe, out_bits;
	logic [3:0] out_digit;
	int errors = 0;
	int tests_run = 0;
	int oq[$];
	int sq[$];
	int i;
	digit_store_read_scanner #(.PHASE_GAP(PG)) uut (.sys_clk(sys_clk), .rst(rst), .write_word(write_word),
		.bit_sel(bit_sel), .wr_advance(wr_advance), .restart(restart), .out_ready(out_ready),
		.first_clock_phase(fp), .second_clock_phase(sp), .rd_slot(rd_slot), .wr_slot(wr_slot),
		.scanning(scanning), .bit_strobe(bit_strobe), .digit_present(digit_present), .out_valid(out_valid),
		.out_bits(out_bits), .out_digit(out_digit), .out_code_err(code_err));
	translation_model #(.GAP(20)) partner (.sys_clk(sys_clk), .rst(rst), .digit_present(digit_present),
		.scanning(scanning), .stall(stall), .restart(restart), .out_ready(out_ready));
	initial forever #10 sys_clk = ~sys_clk;
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [13:0] got, input logic [13:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic adv(input int n);
		repeat (n) begin
			@(posedge fp);
			@(negedge sys_clk);
			@(negedge sys_clk);
		end
	endtask
	// The word is held for a full phase cycle so exactly one second phase samples it.
	task automatic put(input int k, input bit keep);
		if (keep) begin
			oq.push_back(k);
			sq.push_back(k);
		end
		@(posedge sys_clk);
		write_word <= 1'b1;
		bit_sel <= CODES[k];
		repeat (2 * PG) @(posedge sys_clk);
		write_word <= 1'b0;
		bit_sel <= 6'h00;
		@(posedge sys_clk);
		wr_advance <= 1'b1;
		@(posedge sys_clk);
		wr_advance <= 1'b0;
	endtask
	task automatic wait_empty(input bit o);
		int n;
		n = 0;
		while ((o ? oq.size() : sq.size()) != 0 && n < 3000) begin
			@(negedge sys_clk);
			n++;
		end
		chk(14'(n < 3000), 14'h1);
	endtask
	////////////////////////////////////////////////////////////////
	always @(negedge sys_clk) begin
		if (!rst && digit_present === 1'b1) begin
			chk(14'(sq.size() != 0), 14'h1);
			if (sq.size() != 0) chk(14'(bit_strobe), 14'(CODES[sq.pop_front()]));
			chk(14'(scanning), 14'h0);
		end
		if (!rst && out_valid === 1'b1 && out_ready === 1'b1 && oq.size() != 0) begin
			i = oq.pop_front();
			chk(14'(out_bits), 14'(CODES[i]));
			chk(14'(code_err), 14'(i > 9));
			if (i < 10) chk(14'(out_digit), 14'(i));
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic t_clear();
		put(9, 1'b0);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		@(negedge sys_clk);
		chk(wr_slot, 14'h0001);
		chk(rd_slot, 14'h0000);
		chk(14'(scanning), 14'h1);
		$display("test clear done");
	endtask
	task automatic t_scan();
		adv(1);
		chk(rd_slot, 14'h0001);
		adv(1);
		chk(rd_slot, 14'h0002);
		adv(13);
		chk(rd_slot, 14'h0001);
		@(posedge fp);
		@(negedge sys_clk);
		chk(14'(sp), 14'h0);
		repeat (PG) @(negedge sys_clk);
		chk(14'(sp), 14'h1);
		$display("test scan done");
	endtask
	task automatic t_select();
		@(posedge sys_clk);
		bit_sel <= 6'h3F;
		repeat (2 * PG) @(posedge sys_clk);
		bit_sel <= 6'h00;
		write_word <= 1'b1;
		repeat (2 * PG) @(posedge sys_clk);
		write_word <= 1'b0;
		adv(15);
		chk(14'(scanning), 14'h1);
		$display("test select done");
	endtask
	task automatic t_codes();
		for (int k = 0; k < 11; k++) begin
			put(k, 1'b1);
			wait_empty(1'b1);
		end
		adv(16);
		chk(14'(scanning), 14'h1);
		$display("test codes done");
	endtask
	task automatic t_wrap();
		s = wr_slot;
		repeat (14) begin
			@(posedge sys_clk);
			wr_advance <= 1'b1;
			@(posedge sys_clk);
			wr_advance <= 1'b0;
		end
		@(negedge sys_clk);
		chk(wr_slot, s);
		$display("test wrap done");
	endtask
	task automatic t_buffer();
		stall <= 1'b1;
		put(3, 1'b1);
		wait_empty(1'b0);
		put(5, 1'b1);
		wait_empty(1'b0);
		put(7, 1'b1);
		repeat (200) @(negedge sys_clk);
		chk(14'(sq.size()), 14'h1);
		chk(14'(out_valid), 14'h1);
		@(posedge sys_clk);
		stall <= 1'b0;
		wait_empty(1'b1);
		$display("test buffer done");
	endtask
	initial begin
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		t_clear();
		t_scan();
		t_select();
		t_codes();
		t_wrap();
		t_buffer();
		end_of_test();
	end
	initial begin
		#300000;
		errors++;
		end_of_test();
	end
endmodule
